// ==== core/iarr_pkg.sv ====
package iarr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_PHYS_5 = 8'h62;  // remote_phys_addr_slot5
  localparam logic [7:0] OFS_PHYS_6 = 8'h63;  // remote_phys_addr_slot6
  localparam logic [7:0] OFS_PHYS_7 = 8'h64;  // remote_phys_addr_slot7
  localparam logic [7:0] OFS_ALIAS_0 = 8'h65;  // remote_alias_slot0
  localparam logic [7:0] OFS_PORT_SEL = 8'h4c;  // port select, outside this block
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int ADDR_MSB = 7;  // 7-bit address field high bit
  localparam int ADDR_LSB = 1;  // 7-bit address field low bit
  localparam int AUTO_ACK_BIT = 0;  // auto-ack flag in alias slot
  localparam logic [7:0] SLOT_RESET = 8'h00;  // every slot resets to zero
  localparam logic [6:0] ALIAS_OFF = 7'h00;  // alias of zero disables slot
  localparam int NUM_PHYS = 3;  // physical slots 5..7 held here
  localparam int PHYS_BASE = 5;  // first physical slot index
endpackage

// ==== core/iarr_slot_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// per-port copy of slot registers; read data come out of a register
module iarr_slot_mem #(
  parameter int PORTS = 2,
  parameter int PW = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [PW-1:0] wr_port,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [PW-1:0] rd_port,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data_q
);
  // ****************************************
  // storage: four slots per port
  // ****************************************
  logic [7:0] mem_q [PORTS][4];  // slot words

  // writes and registered read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PORTS; p++) begin
        for (int s = 0; s < 4; s++) begin
          mem_q[p][s] <= iarr_pkg::SLOT_RESET;
        end
      end
      rd_data_q <= iarr_pkg::SLOT_RESET;
    end else begin
      if (wr_en) begin
        mem_q[wr_port][wr_idx] <= wr_data;
      end
      rd_data_q <= mem_q[rd_port][rd_idx];
    end
  end
endmodule // iarr_slot_mem
`default_nettype wire

// ==== core/iarr_remap.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - physical slot holds 7-bit address, bit0 zero
// - matching alias replaced by physical address
// - remapped transaction forwarded to remote serializer
// - alias slot holds 7-bit alias for decoding
// - zero alias disables the slot
// - auto-ack bit acknowledges each matched write locally
// - slots per receive port, chosen by port select
// - slots decoded at 0x62..0x65
module iarr_remap #(
  parameter int PORTS = 2,
  parameter int PW = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  // register port of the device
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [PW-1:0] port_sel,
  output logic [7:0] reg_rdata_q,
  output logic reg_hit_q,
  // incoming local transaction address phase
  input wire logic txn_valid,
  input wire logic [PW-1:0] txn_port,
  input wire logic [6:0] txn_addr,
  input wire logic txn_write,
  // forward request toward control channel
  output logic fwd_valid_q,
  output logic [PW-1:0] fwd_port_q,
  output logic [6:0] fwd_addr_q,
  output logic fwd_write_q,
  output logic local_ack_q,
  output logic txn_miss_q
);
  // ****************************************
  // register decode
  // ****************************************
  // decoded slot index: 0..2 physical 5..7, 3 alias 0
  function automatic logic [2:0] slot_dec(input logic [7:0] a);
    unique case (a)
      iarr_pkg::OFS_PHYS_5: slot_dec = 3'h4;
      iarr_pkg::OFS_PHYS_6: slot_dec = 3'h5;
      iarr_pkg::OFS_PHYS_7: slot_dec = 3'h6;
      iarr_pkg::OFS_ALIAS_0: slot_dec = 3'h7;
      default: slot_dec = 3'h0;
    endcase
  endfunction

  wire logic [2:0] dec_w = slot_dec(reg_addr);  // bit2 marks a hit
  wire logic hit_w = dec_w[2];
  wire logic is_alias_w = (dec_w[1:0] == 2'h3);
  // reserved bit0 of physical slots is forced to zero on write
  wire logic [7:0] wdata_w = is_alias_w ? reg_wdata : {reg_wdata[7:1], 1'b0};
  wire logic mem_wr_w = reg_wr && hit_w;
  wire logic [7:0] mem_rd_w;
  logic rd_pend_q;  // read data arrive one cycle later

  iarr_slot_mem #(.PORTS(PORTS), .PW(PW)) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(mem_wr_w),
    .wr_port(port_sel),
    .wr_idx(dec_w[1:0]),
    .wr_data(wdata_w),
    .rd_port(port_sel),
    .rd_idx(dec_w[1:0]),
    .rd_data_q(mem_rd_w)
  );

  // ****************************************
  // alias and physical shadow per port
  // ****************************************
  // shadow copies let the matcher run without a memory read port
  logic [7:0] alias_q [PORTS];
  logic [6:0] phys_q [PORTS];  // physical slot 5, the one alias 0 maps to

  // shadow writes land on the same edge as the memory write, so a match never sees stale slots
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PORTS; p++) begin
        alias_q[p] <= iarr_pkg::SLOT_RESET;
        phys_q[p] <= 7'h00;
      end
    end else if (mem_wr_w && is_alias_w) begin
      alias_q[port_sel] <= reg_wdata;
    end else if (mem_wr_w && dec_w[1:0] == 2'h0) begin
      phys_q[port_sel] <= reg_wdata[iarr_pkg::ADDR_MSB:iarr_pkg::ADDR_LSB];
    end
  end

  // ****************************************
  // register read answer
  // ****************************************
  // two stages: memory register, then output flop; costs a cycle, keeps outputs flop-driven
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
      reg_hit_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      rd_pend_q <= reg_rd && hit_w;
      reg_hit_q <= rd_pend_q;
      // unmapped addresses read zero
      reg_rdata_q <= rd_pend_q ? mem_rd_w : 8'h00;
    end
  end

  // ****************************************
  // alias match and remap
  // ****************************************
  wire logic [7:0] cur_alias_w = alias_q[txn_port];
  wire logic [6:0] cur_alias_addr_w = cur_alias_w[iarr_pkg::ADDR_MSB:iarr_pkg::ADDR_LSB];
  wire logic slot_on_w = (cur_alias_addr_w != iarr_pkg::ALIAS_OFF);
  wire logic match_w = txn_valid && slot_on_w && (txn_addr == cur_alias_addr_w);
  wire logic auto_w = cur_alias_w[iarr_pkg::AUTO_ACK_BIT];

  // forwarding stage: one cycle from request to forward pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_valid_q <= 1'b0;
      fwd_port_q <= '0;
      fwd_addr_q <= 7'h00;
      fwd_write_q <= 1'b0;
      local_ack_q <= 1'b0;
      txn_miss_q <= 1'b0;
    end else begin
      fwd_valid_q <= match_w;
      fwd_port_q <= txn_port;
      fwd_addr_q <= match_w ? phys_q[txn_port] : 7'h00;
      fwd_write_q <= txn_write;
      // ack locally without waiting for link lock or remote ack
      local_ack_q <= match_w && txn_write && auto_w;
      txn_miss_q <= txn_valid && !match_w;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_fwd_remap;
    @(posedge clk) disable iff (sys_rst)
    match_w |=> fwd_valid_q && fwd_addr_q == $past(phys_q[txn_port]);
  endproperty
  a_fwd_remap: assert property (p_fwd_remap) else $error("remap wrong");

  property p_fwd_only_match;
    @(posedge clk) disable iff (sys_rst)
    fwd_valid_q |-> $past(txn_valid) && $past(txn_addr) != 7'h00;
  endproperty
  a_fwd_only_match: assert property (p_fwd_only_match) else $error("spurious forward");

  property p_zero_off;
    @(posedge clk) disable iff (sys_rst)
    (txn_valid && cur_alias_addr_w == 7'h00) |=> !fwd_valid_q && txn_miss_q;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("disabled slot forwarded");

  property p_auto_ack;
    @(posedge clk) disable iff (sys_rst)
    (match_w && txn_write && auto_w) |=> local_ack_q && fwd_valid_q;
  endproperty
  a_auto_ack: assert property (p_auto_ack) else $error("auto ack missing");

  property p_no_ack_off;
    @(posedge clk) disable iff (sys_rst)
    local_ack_q |-> $past(auto_w) && $past(txn_write);
  endproperty
  a_no_ack_off: assert property (p_no_ack_off) else $error("ack without enable");

  property p_phys_bit0;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && hit_w && !is_alias_w) |=> ##1 reg_hit_q && reg_rdata_q[0] == 1'b0;
  endproperty
  a_phys_bit0: assert property (p_phys_bit0) else $error("reserved bit set");

  property p_read_back;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == iarr_pkg::OFS_ALIAS_0) ##1 (reg_rd && !reg_wr
      && reg_addr == iarr_pkg::OFS_ALIAS_0 && port_sel == $past(port_sel))
      |=> ##1 reg_rdata_q == $past(reg_wdata, 3);
  endproperty
  a_read_back: assert property (p_read_back) else $error("alias readback wrong");

  property p_read_latency;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && hit_w) |-> ##2 reg_hit_q;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  // a miss pulse answers only a presented request that found no alias
  property p_miss_src;
    @(posedge clk) disable iff (sys_rst)
    txn_miss_q |-> $past(txn_valid) && !$past(match_w);
  endproperty
  a_miss_src: assert property (p_miss_src) else $error("spurious miss");

  // an idle cycle leaves the forward, miss and ack pulses low
  property p_idle_quiet;
    @(posedge clk) disable iff (sys_rst)
    !txn_valid |=> !fwd_valid_q && !txn_miss_q && !local_ack_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");

  // auto-ack off: a matched request is forwarded but never acked locally
  property p_auto_off;
    @(posedge clk) disable iff (sys_rst)
    (match_w && !auto_w) |=> !local_ack_q && fwd_valid_q;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("ack while auto-ack off");

  // reads outside the decoded window give no answer pulse
  property p_unmapped_quiet;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && !hit_w) |-> ##2 !reg_hit_q;
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("stray hit");
endmodule // iarr_remap
`default_nettype wire

// ==== test/iarr_remote_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side sink: the remote serializer taking each remapped request
module iarr_remote_model (
  input wire logic clk,
  input wire logic fwd_valid_q,
  input wire logic [6:0] fwd_addr_q,
  output var int rx_cnt,
  output var logic [6:0] rx_addr
);
  initial rx_cnt = 0;
  initial rx_addr = 7'h00;
  // the pulse stands one cycle, so it is taken at the edge that ends it
  always @(posedge clk) begin
    if (fwd_valid_q === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_addr <= fwd_addr_q;
    end
  end
endmodule // iarr_remote_model
`default_nettype wire

// ==== test/tb_i2c_remote_alias_remap.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_remote_alias_remap;
  // ****************************************
  // signals and bench copy of the slots
  // ****************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, port_sel = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic txn_valid = 1'b0, txn_port = 1'b0, txn_write = 1'b0;
  logic [6:0] txn_addr = 7'h00;
  logic [7:0] rdata;
  logic hit, fv, fp, fw, la, ms;
  logic [6:0] fa, rx_addr;
  int rx_cnt;
  int error_cnt = 0;
  int num_checks = 0;
  int exp_fwd = 0;
  logic [7:0] mem [2][4];  // per port: phys 5, 6, 7, then alias 0
  always #20 clk = ~clk;
  iarr_remap i_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .port_sel(port_sel), .reg_rdata_q(rdata),
    .reg_hit_q(hit), .txn_valid(txn_valid), .txn_port(txn_port), .txn_addr(txn_addr),
    .txn_write(txn_write), .fwd_valid_q(fv), .fwd_port_q(fp), .fwd_addr_q(fa),
    .fwd_write_q(fw), .local_ack_q(la), .txn_miss_q(ms));
  iarr_remote_model i_far (.clk(clk), .fwd_valid_q(fv), .fwd_addr_q(fa), .rx_cnt(rx_cnt),
    .rx_addr(rx_addr));
  // ****************************************
  // tasks; each starts one ns after an edge
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    port_sel = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    // reserved bit 0 of a physical slot always reads zero
    if (a == iarr_pkg::OFS_ALIAS_0) mem[p][3] = d;
    else if (a >= iarr_pkg::OFS_PHYS_5 && a <= iarr_pkg::OFS_PHYS_7) begin
      mem[p][2'(a - iarr_pkg::OFS_PHYS_5)] = {d[7:1], 1'b0};
    end
  endtask
  task automatic rd(input logic p, input logic [7:0] a);
    logic m;
    m = (a >= iarr_pkg::OFS_PHYS_5) && (a <= iarr_pkg::OFS_ALIAS_0);
    port_sel = p;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 chk("hit", {7'h00, hit}, {7'h00, m});
    if (m) chk("rdata", rdata, mem[p][2'(a - iarr_pkg::OFS_PHYS_5)]);
  endtask
  task automatic txn(input logic p, input logic [6:0] a, input logic w);
    logic h;
    h = (mem[p][3][7:1] != 7'h00) && (mem[p][3][7:1] == a);
    txn_valid = 1'b1;
    txn_port = p;
    txn_addr = a;
    txn_write = w;
    @(posedge clk);
    #1 txn_valid = 1'b0;
    chk("fwd", {7'h00, fv}, {7'h00, h});
    chk("miss", {7'h00, ms}, {7'h00, !h});
    chk("ack", {7'h00, la}, {7'h00, h && w && mem[p][3][0]});
    if (h) begin
      chk("faddr", {1'b0, fa}, {1'b0, mem[p][0][7:1]});
      chk("fport", {6'h00, fp, fw}, {6'h00, p, w});
      exp_fwd++;
    end else begin
      chk("faddr idle", {1'b0, fa}, 8'h00);
    end
    // an idle edge between requests; the far side takes the pulse there
    @(posedge clk);
    #1;
    if (h) chk("remote addr", {1'b0, rx_addr}, {1'b0, mem[p][0][7:1]});
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    logic p;
    logic [7:0] al;
    for (int i = 0; i < 8; i++) mem[i / 4][i % 4] = iarr_pkg::SLOT_RESET;
    void'($urandom(51));
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    txn(1'b0, 7'h00, 1'b1);
    txn(1'b1, 7'($urandom), 1'b1);
    for (int i = 0; i < 16; i++) rd(i[3], 8'h61 + 8'(i % 6));
    // random writes, some unmapped, each read straight back
    for (int i = 0; i < 12; i++) begin
      al = 8'h61 + 8'($urandom % 6);
      p = 1'($urandom);
      wr(p, al, 8'($urandom));
      rd(p, al);
    end
    // alias programming, first round with a zero alias and auto-ack set
    for (int k = 0; k < 10; k++) begin
      al = (k == 0) ? 8'h01 : 8'($urandom);
      wr(1'($urandom), iarr_pkg::OFS_ALIAS_0, al);
      for (int j = 0; j < 6; j++) begin
        p = 1'($urandom);
        txn(p, $urandom % 2 ? al[7:1] : 7'($urandom), 1'($urandom));
      end
    end
    // a second reset mid-run must clear every slot again
    sys_rst = 1'b1;
    for (int i = 0; i < 8; i++) mem[i / 4][i % 4] = iarr_pkg::SLOT_RESET;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    txn(1'b0, al[7:1], 1'b1);
    rd(1'b1, iarr_pkg::OFS_PHYS_5);
    @(posedge clk);
    #1 chk("remote count", 8'(rx_cnt), 8'(exp_fwd));
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule // tb_i2c_remote_alias_remap
`default_nettype wire
